// File: rtl/aisc_top.sv
// control logic for converter input selection, start/stop, window compare and flags
// assumes the analog core takes a start pulse and answers with a done pulse and data
`timescale 1ns/1ps
module aisc_top
	import aisc_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [7:0] o_rd_data,
	input wire logic i_trigger_event,
	input wire logic i_cpu_halted,
	input wire logic i_conv_done,
	input wire logic [15:0] i_conv_data,
	output logic o_conv_start,
	output logic o_conv_abort,
	output logic o_conv_busy,
	output logic o_core_hold,
	output logic [6:0] o_pos_sel,
	output logic [6:0] o_neg_sel,
	output logic o_pos_legal,
	output logic o_neg_legal,
	output logic o_irq_result,
	output logic o_irq_window
);
	function automatic logic pin_code(input logic [6:0] c);
		return (c >= SEL_PIN_LO_A && c <= SEL_PIN_LO_B) ||
			(c >= SEL_PIN_HI_A && c <= SEL_PIN_HI_B) || c == SEL_GND;
	endfunction

	// signed results compare as unsigned once the sign bit is flipped
	function automatic logic [15:0] ordkey(input logic [15:0] v, input logic sgn);
		return {v[15] ^ sgn, v[14:0]};
	endfunction

	function automatic logic win_hit(input logic [15:0] r, input logic [15:0] lo,
		input logic [15:0] hi, input logic [2:0] m, input logic sgn);
		logic below;
		logic above;
		below = ordkey(r, sgn) < ordkey(lo, sgn);
		above = ordkey(r, sgn) > ordkey(hi, sgn);
		case (m) // R17
			WM_BELOW: return below;
			WM_ABOVE: return above;
			WM_INSIDE: return !below && !above;
			WM_OUTSIDE: return below || above;
			default: return 1'b0;
		endcase
	endfunction

	aisc_state_t state_ff, nxt_state;
	logic cont_ff, nxt_cont;
	logic sgn_ff, nxt_sgn;
	logic [2:0] wmode_ff, nxt_wmode;
	logic [6:0] pos_ff, nxt_pos, neg_ff, nxt_neg;
	logic [6:0] pos_app_ff, nxt_pos_app, neg_app_ff, nxt_neg_app;
	logic trig_en_ff, nxt_trig_en;
	logic [1:0] ien_ff, nxt_ien, flg_ff, nxt_flg;
	logic keep_ff, nxt_keep;
	logic [7:0] stage_ff, nxt_stage;
	logic [15:0] res_ff, nxt_res, low_ff, nxt_low, up_ff, nxt_up;
	logic pend_ff, nxt_pend;
	logic evt_q_ff;
	logic start_ff, nxt_start, abort_ff, nxt_abort;
	logic [7:0] rdata_ff, nxt_rdata;
	logic wr_cmd, stop_cmd, start_cmd, evt_rise, launch_req, run_ok, rd_res;
	logic [1:0] flg_set, flg_clr;

	always_comb begin
		wr_cmd = i_wr_stb && i_addr == OFS_CMD;
		stop_cmd = wr_cmd && i_wr_data[BIT_STOP];
		start_cmd = wr_cmd && i_wr_data[BIT_START];
		evt_rise = trig_en_ff && i_trigger_event && !evt_q_ff; // R8
		launch_req = pend_ff || start_cmd || evt_rise; // R6
		// held by the debugger unless told to keep running
		run_ok = !(i_cpu_halted && !keep_ff); // R13
		rd_res = i_rd_stb && (i_addr == OFS_RES_L || i_addr == OFS_RES_H);
		nxt_state = state_ff;
		nxt_pend = pend_ff;
		nxt_start = 1'b0;
		nxt_abort = 1'b0;
		nxt_res = res_ff;
		flg_set = 2'b00;
		nxt_pos_app = pos_app_ff;
		nxt_neg_app = neg_app_ff;
		case (state_ff)
			ST_IDLE: begin
				nxt_pos_app = pos_ff;
				nxt_neg_app = neg_ff;
				if (stop_cmd) begin
					nxt_pend = 1'b0; // R5
				end else if (launch_req && run_ok) begin
					nxt_state = ST_BUSY;
					nxt_start = 1'b1;
					nxt_pend = 1'b0;
				end else if (launch_req) begin
					nxt_pend = 1'b1;
				end
			end
			ST_BUSY: begin
				if (stop_cmd) begin
					nxt_state = ST_IDLE; // R5
					nxt_abort = 1'b1;
					nxt_pend = 1'b0;
				end else if (i_conv_done) begin
					nxt_res = i_conv_data;
					flg_set[BIT_RDY] = 1'b1; // R11
					flg_set[BIT_WIN] = win_hit(i_conv_data, low_ff, up_ff, wmode_ff, sgn_ff); // R10
					nxt_pos_app = pos_ff; // R1
					nxt_neg_app = neg_ff; // R1
					if ((launch_req || cont_ff) && run_ok) begin
						nxt_start = 1'b1; // R19
						nxt_pend = 1'b0;
					end else begin
						nxt_state = ST_IDLE;
						nxt_pend = launch_req || cont_ff;
					end
				end else if (start_cmd || evt_rise) begin
					nxt_pend = 1'b1; // R6
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_pend = 1'b0;
			end
		endcase
	end

	always_comb begin
		nxt_cont = cont_ff;
		nxt_sgn = sgn_ff;
		nxt_wmode = wmode_ff;
		nxt_pos = pos_ff;
		nxt_neg = neg_ff;
		nxt_trig_en = trig_en_ff;
		nxt_ien = ien_ff;
		nxt_keep = keep_ff;
		nxt_stage = stage_ff;
		nxt_low = low_ff;
		nxt_up = up_ff;
		flg_clr = rd_res ? 2'b11 : 2'b00; // R12
		if (i_wr_stb) begin
			case (i_addr)
				OFS_CTRL: begin
					nxt_cont = i_wr_data[BIT_CONT];
					nxt_sgn = i_wr_data[BIT_SIGNED];
				end
				OFS_WMODE: nxt_wmode = i_wr_data[2:0];
				OFS_POS: nxt_pos = i_wr_data[6:0];
				OFS_NEG: nxt_neg = i_wr_data[6:0];
				OFS_TRIG: nxt_trig_en = i_wr_data[BIT_TRIG_EN];
				OFS_IEN: nxt_ien = i_wr_data[1:0];
				OFS_IFLG: flg_clr = flg_clr | i_wr_data[1:0]; // R12
				OFS_HALT: nxt_keep = i_wr_data[BIT_KEEP];
				OFS_STAGE: nxt_stage = i_wr_data; // R14
				OFS_LOW_L: nxt_stage = i_wr_data; // R20
				OFS_LOW_H: nxt_low = {i_wr_data, stage_ff}; // R16
				OFS_UP_L: nxt_stage = i_wr_data; // R20
				OFS_UP_H: nxt_up = {i_wr_data, stage_ff}; // R18
				default: nxt_stage = stage_ff;
			endcase
		end
		if (i_rd_stb) begin
			case (i_addr)
				OFS_RES_L: nxt_stage = res_ff[15:8]; // R20
				OFS_LOW_L: nxt_stage = low_ff[15:8]; // R20
				OFS_UP_L: nxt_stage = up_ff[15:8]; // R20
				default: nxt_stage = nxt_stage;
			endcase
		end
		// an event in the clearing cycle survives
		nxt_flg = (flg_ff & ~flg_clr) | flg_set; // R12
	end

	always_comb begin
		nxt_rdata = RST_BYTE;
		if (i_rd_stb) begin
			case (i_addr)
				OFS_CTRL: nxt_rdata = {2'b00, sgn_ff, 3'b000, cont_ff, 1'b0};
				OFS_WMODE: nxt_rdata = {5'b00000, wmode_ff};
				OFS_POS: nxt_rdata = {1'b0, pos_ff};
				OFS_NEG: nxt_rdata = {1'b0, neg_ff};
				OFS_CMD: nxt_rdata = {7'b0000000, state_ff == ST_BUSY || pend_ff}; // R7
				OFS_TRIG: nxt_rdata = {7'b0000000, trig_en_ff};
				OFS_IEN: nxt_rdata = {6'b000000, ien_ff};
				OFS_IFLG: nxt_rdata = {6'b000000, flg_ff};
				OFS_HALT: nxt_rdata = {7'b0000000, keep_ff};
				OFS_STAGE: nxt_rdata = stage_ff; // R14
				OFS_RES_L: nxt_rdata = res_ff[7:0]; // R15
				OFS_RES_H: nxt_rdata = stage_ff; // R20
				OFS_LOW_L: nxt_rdata = low_ff[7:0];
				OFS_LOW_H: nxt_rdata = stage_ff;
				OFS_UP_L: nxt_rdata = up_ff[7:0];
				OFS_UP_H: nxt_rdata = stage_ff;
				default: nxt_rdata = RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_ff <= ST_IDLE;
			cont_ff <= 1'b0;
			sgn_ff <= 1'b0;
			wmode_ff <= WM_NONE;
			pos_ff <= 7'h00;
			neg_ff <= 7'h00;
			pos_app_ff <= 7'h00;
			neg_app_ff <= 7'h00;
			trig_en_ff <= 1'b0;
			ien_ff <= 2'h0;
			flg_ff <= 2'h0;
			keep_ff <= 1'b0;
			stage_ff <= RST_BYTE;
			res_ff <= RST_WORD;
			low_ff <= RST_WORD;
			up_ff <= RST_WORD;
			pend_ff <= 1'b0;
			evt_q_ff <= 1'b0;
			start_ff <= 1'b0;
			abort_ff <= 1'b0;
			rdata_ff <= RST_BYTE;
		end else begin
			state_ff <= nxt_state;
			cont_ff <= nxt_cont;
			sgn_ff <= nxt_sgn;
			wmode_ff <= nxt_wmode;
			pos_ff <= nxt_pos;
			neg_ff <= nxt_neg;
			pos_app_ff <= nxt_pos_app;
			neg_app_ff <= nxt_neg_app;
			trig_en_ff <= nxt_trig_en;
			ien_ff <= nxt_ien;
			flg_ff <= nxt_flg;
			keep_ff <= nxt_keep;
			stage_ff <= nxt_stage;
			res_ff <= nxt_res;
			low_ff <= nxt_low;
			up_ff <= nxt_up;
			pend_ff <= nxt_pend;
			evt_q_ff <= i_trigger_event;
			start_ff <= nxt_start;
			abort_ff <= nxt_abort;
			rdata_ff <= nxt_rdata;
		end
	end

	assign o_rd_data = rdata_ff;
	assign o_conv_start = start_ff;
	assign o_conv_abort = abort_ff;
	assign o_conv_busy = state_ff == ST_BUSY;
	assign o_core_hold = !run_ok;
	assign o_pos_sel = pos_app_ff;
	assign o_neg_sel = neg_app_ff;
	// reserved codes are flagged, not blocked; the analog side decides
	assign o_pos_legal = pin_code(pos_app_ff) || (pos_app_ff >= SEL_THERMAL &&
		pos_app_ff <= SEL_IO2_TENTH) || pos_app_ff == SEL_CONV_OUT ||
		pos_app_ff == SEL_CONV_REF; // R2 R3
	assign o_neg_legal = pin_code(neg_app_ff) || neg_app_ff == SEL_CONV_OUT; // R4
	assign o_irq_result = flg_ff[BIT_RDY] && ien_ff[BIT_RDY]; // R9
	assign o_irq_window = flg_ff[BIT_WIN] && ien_ff[BIT_WIN]; // R9

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	sequence idle_start_s;
		state_ff == ST_IDLE && start_cmd && !stop_cmd && run_ok;
	endsequence
	sequence done_s;
		state_ff == ST_BUSY && i_conv_done && !stop_cmd;
	endsequence

	start_launch_a: assert property (idle_start_s |=> o_conv_start && o_conv_busy) // R6
		else $error("start write did not launch a conversion");
	stop_wins_a: assert property (o_conv_busy && stop_cmd |=> !o_conv_busy // R5
		&& o_conv_abort && !o_conv_start)
		else $error("stop did not end the conversion");
	busy_readback_a: assert property (i_rd_stb && i_addr == OFS_CMD && o_conv_busy // R7
		|=> o_rd_data[BIT_START])
		else $error("start bit not read as one while busy");
	select_hold_a: assert property (o_conv_busy && !i_conv_done && !stop_cmd // R1
		|=> $stable(o_pos_sel) && $stable(o_neg_sel))
		else $error("selection changed during a conversion");
	ready_set_a: assert property (done_s |=> flg_ff[BIT_RDY] // R11
		&& res_ff == $past(i_conv_data))
		else $error("result ready not set on completion");
	flag_clear_a: assert property (rd_res // R12
		&& !(state_ff == ST_BUSY && i_conv_done && !stop_cmd) |=> flg_ff == 2'b00)
		else $error("result read did not clear flags");
	event_launch_a: assert property (state_ff == ST_IDLE && evt_rise && run_ok // R8
		&& !stop_cmd |=> o_conv_start)
		else $error("event edge did not start a conversion");
	cont_restart_a: assert property (done_s ##0 (cont_ff && run_ok) |=> o_conv_start // R19
		&& o_conv_busy)
		else $error("continuous mode did not restart");
	irq_gate_a: assert property (o_irq_window |-> flg_ff[BIT_WIN] && ien_ff[BIT_WIN]) // R9
		else $error("window interrupt without flag and enable");
	halt_hold_a: assert property (!run_ok |=> !o_conv_start) // R13
		else $error("conversion launched while halted");
endmodule // aisc_top

// File: rtl/aisc_pkg.sv
// constants for the converter input-select and result control block
// assumes one 10 MHz clock and a byte-wide register port with reads answered one cycle later
// Summary of operation
// (R1) a selection written during a conversion reaches the multiplexer only after it ends
// (R2) positive codes 01-07 and 10-1F route external pins, 40 routes ground
// (R3) positive 42/43 thermal sensors, 44/45 supply tenths, 48/49 converter out/reference
// (R4) negative codes: pins 01-07, 10-1F, ground 40, converter out 48; rest reserved
// (R5) stop bit one ends the measurement and beats a simultaneous start
// (R6) start bit one launches a conversion once the running one completes
// (R7) start bit reads one while a conversion runs, clears itself on completion
// (R8) with event trigger enabled, each rising event edge starts a conversion
// (R9) irq enable bit 1 window match, bit 0 result ready; flag and enable both needed
// (R10) at each conversion end the result is compared; window flag set on a hit
// (R11) result ready flag set whenever a measurement completes
// (R12) flags clear on writing one or reading the result; writing zero does nothing
// (R13) keep-running bit lets conversions go on while the processor is halted
// (R14) one shared staging byte at 0F serves all 16-bit registers, also directly
// (R15) read-only 16-bit result, low byte at 10, high byte at 11
// (R16) lower limit at 12, low byte first, in the same format as the result
// (R17) window mode: 0 none, 1 below, 2 above, 3 inside inclusive, 4 outside
// (R18) upper limit at 14, low byte at the base offset
// (R19) continuous mode restarts conversions back to back after the first one
// (R20) low-byte read stages the high byte; low-byte write waits for the high write
package aisc_pkg;
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_WMODE = 5'h04;
	localparam logic [4:0] OFS_POS = 5'h08;
	localparam logic [4:0] OFS_NEG = 5'h09;
	localparam logic [4:0] OFS_CMD = 5'h0A;
	localparam logic [4:0] OFS_TRIG = 5'h0B;
	localparam logic [4:0] OFS_IEN = 5'h0C;
	localparam logic [4:0] OFS_IFLG = 5'h0D;
	localparam logic [4:0] OFS_HALT = 5'h0E;
	localparam logic [4:0] OFS_STAGE = 5'h0F;
	localparam logic [4:0] OFS_RES_L = 5'h10;
	localparam logic [4:0] OFS_RES_H = 5'h11;
	localparam logic [4:0] OFS_LOW_L = 5'h12;
	localparam logic [4:0] OFS_LOW_H = 5'h13;
	localparam logic [4:0] OFS_UP_L = 5'h14;
	localparam logic [4:0] OFS_UP_H = 5'h15;
	localparam int BIT_CONT = 1;
	localparam int BIT_SIGNED = 5;
	localparam int BIT_START = 0;
	localparam int BIT_STOP = 1;
	localparam int BIT_TRIG_EN = 0;
	localparam int BIT_WIN = 1;
	localparam int BIT_RDY = 0;
	localparam int BIT_KEEP = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [2:0] WM_NONE = 3'h0;
	localparam logic [2:0] WM_BELOW = 3'h1;
	localparam logic [2:0] WM_ABOVE = 3'h2;
	localparam logic [2:0] WM_INSIDE = 3'h3;
	localparam logic [2:0] WM_OUTSIDE = 3'h4;
	localparam logic [6:0] SEL_PIN_LO_A = 7'h01;
	localparam logic [6:0] SEL_PIN_LO_B = 7'h07;
	localparam logic [6:0] SEL_PIN_HI_A = 7'h10;
	localparam logic [6:0] SEL_PIN_HI_B = 7'h1F;
	localparam logic [6:0] SEL_GND = 7'h40;
	localparam logic [6:0] SEL_THERMAL = 7'h42;
	localparam logic [6:0] SEL_THERMAL_EXP = 7'h43;
	localparam logic [6:0] SEL_SUPPLY_TENTH = 7'h44;
	localparam logic [6:0] SEL_IO2_TENTH = 7'h45;
	localparam logic [6:0] SEL_CONV_OUT = 7'h48;
	localparam logic [6:0] SEL_CONV_REF = 7'h49;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_BUSY = 2'b10
	} aisc_state_t;
endpackage

// File: tb/aisc_core_model.sv
// stand-in for the analog core: answers a start pulse with done and data
// assumes start and abort are one-cycle pulses from the control block
`timescale 1ns/1ps
module aisc_core_model (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic i_start,
	input wire logic i_abort,
	input wire logic [7:0] i_delay,
	input wire logic [15:0] i_next,
	output logic o_done,
	output logic [15:0] o_data
);
	logic [7:0] cnt_ff;
	logic [15:0] dat_ff;
	// data inverted outside done so stale use shows
	assign o_data = o_done ? dat_ff : ~dat_ff;
	always_ff @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		if (!i_reset_n || i_abort) begin
			cnt_ff <= 8'h00;
			dat_ff <= 16'h0000;
		end else if (i_start) begin
			cnt_ff <= i_delay;
		end else if (cnt_ff == 8'h01) begin
			cnt_ff <= 8'h00;
			o_done <= 1'b1;
			dat_ff <= i_next;
		end else if (cnt_ff != 8'h00) begin
			cnt_ff <= cnt_ff - 8'h01;
		end
	end
endmodule // aisc_core_model

// File: tb/aisc_top_tb.sv
// self-checking bench for the converter control block
// assumes aisc_core_model answers starts after a chosen delay
`timescale 1ns/1ps
module aisc_top_tb import aisc_pkg::*;;
	logic i_sys_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [7:0] i_wr_data = 8'h00;
	logic i_wr_stb = 1'b0;
	logic i_rd_stb = 1'b0;
	logic i_trigger_event = 1'b0;
	logic i_cpu_halted = 1'b0;
	logic i_conv_done;
	logic [15:0] i_conv_data;
	logic [7:0] o_rd_data;
	logic o_conv_start, o_conv_abort, o_conv_busy, o_core_hold;
	logic [6:0] o_pos_sel, o_neg_sel;
	logic o_pos_legal, o_neg_legal, o_irq_result, o_irq_window;
	logic [7:0] dly = 8'h08;
	logic [15:0] nxt = 16'h0000;
	logic [7:0] exp_q[$];
	logic rd_seen = 1'b0;
	int error_cnt = 0;
	int checks = 0;
	int starts = 0;
	int aborts = 0;

	aisc_top i_dut (.i_sys_clk, .i_reset_n, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data,
		.i_trigger_event, .i_cpu_halted, .i_conv_done, .i_conv_data, .o_conv_start, .o_conv_abort,
		.o_conv_busy, .o_core_hold, .o_pos_sel, .o_neg_sel, .o_pos_legal, .o_neg_legal,
		.o_irq_result, .o_irq_window);
	aisc_core_model i_core (.i_sys_clk, .i_reset_n, .i_start(o_conv_start),
		.i_abort(o_conv_abort), .i_delay(dly), .i_next(nxt), .o_done(i_conv_done),
		.o_data(i_conv_data));

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic op(input logic w, input logic r, input logic [4:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		i_wr_stb <= w;
		i_rd_stb <= r;
		i_addr <= a;
		i_wr_data <= d;
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		op(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] e);
		op(1'b0, 1'b1, a, 8'h00);
		exp_q.push_back(e);
	endtask
	task automatic idle(input int n);
		repeat (n) op(1'b0, 1'b0, 5'h00, 8'h00);
	endtask
	task automatic wr16(input logic [4:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 5'h01, v[15:8]);
	endtask
	// selection written mid-conversion must wait for the end
	task automatic conv(input logic [15:0] v, input logic [7:0] d);
		int n;
		wr(OFS_POS, 8'(SEL_GND));
		idle(2);
		nxt <= v;
		dly <= d;
		wr(OFS_CMD, 8'h01);
		wr(OFS_POS, 8'(SEL_THERMAL));
		idle(1);
		rd(OFS_CMD, 8'h01);
		#1;
		chk("pos busy", 16'(SEL_GND), 16'(o_pos_sel));
		n = 0;
		while (o_conv_busy === 1'b1 && n < 300) begin
			idle(1);
			n++;
		end
		idle(1);
		#1;
		chk("pos done", 16'(SEL_THERMAL), 16'(o_pos_sel));
		chk("busy", 16'h0000, 16'(o_conv_busy));
	endtask
	function automatic logic hit(input logic [2:0] m, input logic [15:0] r, lo, hi);
		case (m)
			WM_BELOW: return r < lo;
			WM_ABOVE: return r > hi;
			WM_INSIDE: return (r >= lo) && (r <= hi);
			WM_OUTSIDE: return (r < lo) || (r > hi);
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic leg(input logic [6:0] c, input logic p);
		return (c >= 7'h01 && c <= 7'h07) || (c >= 7'h10 && c <= 7'h1F) || c == 7'h40
			|| c == 7'h48 || (p && ((c >= 7'h42 && c <= 7'h45) || c == 7'h49));
	endfunction
	task automatic print_verdict();
		if (error_cnt == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		forever #50 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk) begin
		if (rd_seen) begin
			chk("read", 16'(exp_q.pop_front()), 16'(o_rd_data));
		end
		rd_seen <= i_rd_stb;
		if (o_conv_start === 1'b1) begin
			starts <= starts + 1;
		end
		if (o_conv_abort === 1'b1) begin
			aborts <= aborts + 1;
		end
	end
	// a hang would otherwise never reach the verdict
	initial begin
		#1ms;
		error_cnt++;
		print_verdict();
	end

	initial begin
		logic [15:0] lo, hi, r;
		logic [2:0] m;
		logic w;
		int s0;
		void'($urandom(12));
		repeat (20) @(posedge i_sys_clk);
		i_reset_n <= 1'b1;
		for (int a = 0; a < 32; a++) begin
			rd(5'(a), RST_BYTE);
		end
		for (int c = 0; c < 128; c++) begin
			wr(OFS_POS, 8'(c));
			wr(OFS_NEG, 8'(c));
			rd(OFS_POS, 8'(c));
			rd(OFS_NEG, 8'(c));
			idle(2);
			#1;
			chk("pos", 16'(c), 16'(o_pos_sel));
			chk("neg", 16'(c), 16'(o_neg_sel));
			chk("pos ok", 16'(leg(7'(c), 1'b1)), 16'(o_pos_legal));
			chk("neg ok", 16'(leg(7'(c), 1'b0)), 16'(o_neg_legal));
		end
		lo = 16'($urandom);
		wr(OFS_STAGE, 8'h5A);
		rd(OFS_STAGE, 8'h5A);
		wr(OFS_LOW_L, lo[7:0]);
		rd(OFS_STAGE, lo[7:0]);
		wr(OFS_LOW_H, lo[15:8]);
		rd(OFS_LOW_L, lo[7:0]);
		rd(OFS_STAGE, lo[15:8]);
		rd(OFS_LOW_H, lo[15:8]);
		for (int k = 0; k < 10; k++) begin
			m = 3'(k % 5);
			lo = 16'($urandom_range(32768));
			hi = lo + 16'($urandom_range(16384));
			r = (k < 5) ? ((k % 2 == 1) ? lo : hi) : 16'($urandom);
			w = hit(m, r, lo, hi);
			wr(OFS_IEN, (k == 9) ? 8'h00 : 8'h03);
			wr(OFS_WMODE, {5'h00, m});
			wr16(OFS_LOW_L, lo);
			wr16(OFS_UP_L, hi);
			wr(OFS_RES_L, 8'hFF);
			conv(r, 8'(4 + k));
			chk("irq rdy", 16'(k != 9), 16'(o_irq_result));
			chk("irq win", 16'(k != 9 && w), 16'(o_irq_window));
			wr(OFS_IFLG, 8'h00);
			rd(OFS_IFLG, {6'h00, w, 1'b1});
			if (k % 2 == 1) begin
				wr(OFS_IFLG, 8'h03);
				rd(OFS_IFLG, 8'h00);
			end
			rd(OFS_RES_L, r[7:0]);
			rd(OFS_RES_H, r[15:8]);
			rd(OFS_IFLG, 8'h00);
		end
		// signed compare: a negative result lies below a small positive limit
		wr(OFS_CTRL, 8'h20);
		rd(OFS_CTRL, 8'h20);
		wr(OFS_WMODE, {5'h00, WM_BELOW});
		wr16(OFS_LOW_L, 16'h0010);
		conv(16'hFFF0, 8'h05);
		rd(OFS_IFLG, 8'h03);
		rd(OFS_RES_L, 8'hF0);
		rd(OFS_RES_H, 8'hFF);
		wr(OFS_CTRL, 8'h00);
		dly <= 8'h28;
		wr(OFS_CMD, 8'h01);
		idle(3);
		wr(OFS_CMD, 8'h03);
		idle(2);
		#1;
		chk("stop", 16'h0000, 16'(o_conv_busy));
		chk("abort", 16'h0001, 16'(aborts));
		rd(OFS_CMD, 8'h00);
		idle(50);
		rd(OFS_IFLG, 8'h00);
		dly <= 8'h08;
		s0 = starts;
		wr(OFS_CMD, 8'h01);
		idle(2);
		wr(OFS_CMD, 8'h01);
		idle(30);
		chk("pended", 16'(s0 + 2), 16'(starts));
		s0 = starts;
		for (int e = 0; e < 2; e++) begin
			wr(OFS_TRIG, 8'(e));
			idle(2);
			i_trigger_event <= 1'b1;
			idle(3);
			i_trigger_event <= 1'b0;
			idle(25);
			chk("event", 16'(s0 + e), 16'(starts));
		end
		i_cpu_halted <= 1'b1;
		for (int h = 0; h < 2; h++) begin
			wr(OFS_HALT, 8'(h));
			rd(OFS_HALT, 8'(h));
			idle(2);
			#1;
			chk("hold", 16'(1 - h), 16'(o_core_hold));
		end
		i_cpu_halted <= 1'b0;
		s0 = starts;
		wr(OFS_CTRL, 8'h02);
		wr(OFS_CMD, 8'h01);
		idle(40);
		chk("continuous", 16'h0001, 16'(starts >= s0 + 3));
		wr(OFS_CMD, 8'h02);
		wr(OFS_CTRL, 8'h00);
		idle(3);
		#1;
		chk("stop", 16'h0000, 16'(o_conv_busy));
		chk("abort", 16'h0002, 16'(aborts));
		idle(3);
		print_verdict();
	end
endmodule // aisc_top_tb
